// [hw/cbx_defines.vh]
`ifndef CBX_DEFINES_VH
`define CBX_DEFINES_VH
// Operation codes
`define CBX_OP_ADD      6'h00
`define CBX_OP_ADC      6'h01
`define CBX_OP_SUB      6'h02
`define CBX_OP_SBC      6'h03
`define CBX_OP_AND      6'h04
`define CBX_OP_OR       6'h05
`define CBX_OP_XOR      6'h06
`define CBX_OP_CMP      6'h07
`define CBX_OP_MULS     6'h08
`define CBX_OP_MULU     6'h09
`define CBX_OP_DIVS     6'h0A
`define CBX_OP_QUOTIENT_UNSIGNED     6'h0B
`define CBX_OP_INC      6'h0C
`define CBX_OP_DEC      6'h0D
`define CBX_OP_BCD      6'h0E
`define CBX_OP_ONES     6'h0F
`define CBX_OP_NEG      6'h10
`define CBX_OP_SEXT     6'h11
`define CBX_OP_WADD     6'h12
`define CBX_OP_WSUB     6'h13
`define CBX_OP_WCMP     6'h14
`define CBX_OP_WMULS    6'h15
`define CBX_OP_WMULU    6'h16
`define CBX_OP_WDIVS    6'h17
`define CBX_OP_WDIVU    6'h18
`define CBX_OP_WSEXT    6'h19
`define CBX_OP_WINC     6'h1A
`define CBX_OP_WDEC     6'h1B
`define CBX_OP_XADD     6'h1C
`define CBX_OP_XADC     6'h1D
`define CBX_OP_XSBC     6'h1E
`define CBX_OP_XADDA    6'h1F
`define CBX_OP_WNEG     6'h20
// Block operation: bit0 down, bit1 repeat, bit2 search
`define CBX_BLK_DOWN    0
`define CBX_BLK_RUN     1
`define CBX_BLK_SRCH    2
// Flag positions
`define CBX_F_C         0
`define CBX_F_N         1
`define CBX_F_PV        2
`define CBX_F_H         4
`define CBX_F_Z         6
`define CBX_F_S         7
`define CBX_BUF_DEPTH   2
`endif

// [hw/cbx_exec.v]
// Contract
// (RQ1) Block copy/search, 16-bit length up to 65536
// (RQ2) Increment and decrement forms of each
// (RQ3) Repeat until count zero or match
// (RQ4) Step form: one unit, count minus one
// (RQ5) counter_pair length, pointers, accumulator search byte
// (RQ6) Repeat interruptible between iterations, restartable state
// (RQ7) Byte two-operand ops use accumulator plus operand
// (RQ8) Byte products to primary_pair, others accumulator
// (RQ9) Signed and unsigned byte division provided
// (RQ10) Byte inc/dec written back to operand
// (RQ11) Decimal adjust, complements act on accumulator only; WNEG negates primary_pair
// (RQ12) Byte sign widen accumulator into primary_pair
// (RQ13) Byte ops set flags except sign widen
// (RQ14) Only divides raise exceptions
// (RQ15) Word add/adc/sbc onto addressing register
// (RQ16) Word inc/dec on register or memory word
// (RQ17) Accumulator added as signed index
// (RQ18) Word ops use primary_pair plus operand
// (RQ19) Word product: secondary high, primary low
// (RQ20) Word divide 32/16, quotient primary, remainder secondary
// (RQ21) Word sign widen primary into secondary
// (RQ22) Word ops set flags except inc/dec/widen; XADDA sets no flags
// (RQ23) Divide fault on zero divisor or overflow
// (RQ24) Byte divide: primary_pair dividend, quotient accumulator
`timescale 1ns/1ps
`include "cbx_defines.vh"
`default_nettype none
module cbx_exec (
   input  wire        core_clk,
   input  wire        reset,
   input  wire        alu_req,
   input  wire [5:0]  alu_op,
   input  wire [15:0] alu_operand,
   input  wire [15:0] alu_xreg,
   output reg         alu_done,
   output reg         div_fault,
   output reg         alu_dst_xreg,
   output reg         alu_dst_opnd,
   output reg  [15:0] alu_opnd_out,
   input  wire        blk_req,
   input  wire [2:0]  blk_op,
   input  wire        irq_pending,
   output reg         blk_done,
   output reg         blk_irq_exit,
   output reg         blk_matched,
   output reg         mem_rd,
   output reg         mem_wr,
   output reg  [15:0] mem_addr,
   output reg  [7:0]  mem_wdata,
   input  wire        mem_ack,
   input  wire [7:0]  mem_rdata,
   output reg  [7:0]  acc_q,
   output reg  [7:0]  flags_q,
   output reg  [15:0] counter_pair_q,
   output reg  [15:0] secondary_pair_q,
   output reg  [15:0] primary_pair_q,
   input  wire        load_en,
   input  wire [7:0]  load_acc,
   input  wire [7:0]  load_flags,
   input  wire [15:0] load_counter,
   input  wire [15:0] load_secondary,
   input  wire [15:0] load_primary
);
   localparam ST_IDLE = 3'h0;
   localparam ST_RD   = 3'h1;
   localparam ST_BUF  = 3'h2;
   localparam ST_WR   = 3'h3;
   localparam ST_STEP = 3'h4;
   reg  [2:0]  st_q;
   reg  [2:0]  bop_q;
   // Two-entry buffer between read and write
   reg  [7:0]  buf_q [0:1];
   reg         wp_q;
   reg         rp_q;
   reg  [1:0]  cnt_q;
   wire        buf_full  = (cnt_q == 2'h2);
   wire        buf_empty = (cnt_q == 2'h0);
   wire [7:0]  buf_head  = buf_q[rp_q];
   function [7:0] flg8;
      input [7:0] r;
      input       c, n, v, h;
      begin
         flg8 = 8'h00;
         flg8[`CBX_F_S]  = r[7];
         flg8[`CBX_F_Z]  = (r == 8'h00);
         flg8[`CBX_F_C]  = c;
         flg8[`CBX_F_N]  = n;
         flg8[`CBX_F_PV] = v;
         flg8[`CBX_F_H]  = h;
      end
   endfunction
   // Byte datapath
   wire        cin = flags_q[`CBX_F_C];
   wire [7:0]  bop = alu_operand[7:0];
   wire [8:0]  b_add = {1'b0, acc_q} + {1'b0, bop} + {8'h00, (alu_op == `CBX_OP_ADC) & cin};
   wire [8:0]  b_sub = {1'b0, acc_q} - {1'b0, bop} - {8'h00, (alu_op == `CBX_OP_SBC) & cin};
   wire [15:0] b_mulu = {8'h00, acc_q} * {8'h00, bop};
   wire signed [15:0] b_muls = $signed({{8{acc_q[7]}}, acc_q}) * $signed({{8{bop[7]}}, bop});
   wire [15:0] b_dvs = primary_pair_q[15] ? (16'h0000 - primary_pair_q) : primary_pair_q;
   wire [7:0]  b_dsr = bop[7] ? (8'h00 - bop) : bop;
   wire        b_sgn = (alu_op == `CBX_OP_DIVS);
   wire [15:0] b_num = b_sgn ? b_dvs : primary_pair_q;
   wire [7:0]  b_den = b_sgn ? b_dsr : bop;
   wire [15:0] b_q   = (b_den == 8'h00) ? 16'h0000 : b_num / {8'h00, b_den};
   wire [15:0] b_r   = (b_den == 8'h00) ? 16'h0000 : b_num % {8'h00, b_den};
   wire        b_qneg = primary_pair_q[15] ^ bop[7];
   wire [7:0]  b_qs  = b_qneg ? (8'h00 - b_q[7:0]) : b_q[7:0];
   wire [7:0]  b_rs  = primary_pair_q[15] ? (8'h00 - b_r[7:0]) : b_r[7:0];
   wire        b_ovf = b_sgn ? ((b_q > 16'h0080) || (b_q == 16'h0080 && !b_qneg)) : (b_q[15:8] != 8'h00);
   // Word datapath
   wire [16:0] w_add = {1'b0, primary_pair_q} + {1'b0, alu_operand};
   wire [16:0] w_sub = {1'b0, primary_pair_q} - {1'b0, alu_operand};
   wire [31:0] w_mulu = {16'h0000, primary_pair_q} * {16'h0000, alu_operand};
   wire signed [31:0] w_muls = $signed({{16{primary_pair_q[15]}}, primary_pair_q})
                             * $signed({{16{alu_operand[15]}}, alu_operand});
   wire [31:0] w_dvd  = {secondary_pair_q, primary_pair_q};
   wire        w_sgn  = (alu_op == `CBX_OP_WDIVS);
   wire [31:0] w_num  = (w_sgn & w_dvd[31]) ? (32'h00000000 - w_dvd) : w_dvd;
   wire [15:0] w_den  = (w_sgn & alu_operand[15]) ? (16'h0000 - alu_operand) : alu_operand;
   wire [31:0] w_q    = (w_den == 16'h0000) ? 32'h00000000 : w_num / {16'h0000, w_den};
   wire [31:0] w_r    = (w_den == 16'h0000) ? 32'h00000000 : w_num % {16'h0000, w_den};
   wire        w_qneg = w_dvd[31] ^ alu_operand[15];
   wire        w_ovf  = w_sgn ? ((w_q > 32'h00008000) || (w_q == 32'h00008000 && !w_qneg))
                              : (w_q[31:16] != 16'h0000);
   wire [16:0] x_adc  = {1'b0, alu_xreg} + {1'b0, alu_operand} + {16'h0000, (alu_op == `CBX_OP_XADC) & cin};
   wire [16:0] x_sbc  = {1'b0, alu_xreg} - {1'b0, alu_operand} - {16'h0000, cin};
   // Bcd fixup correction
   wire [7:0]  bcd_c  = {((acc_q > 8'h99) | cin) ? 4'h6 : 4'h0,
                         ((acc_q[3:0] > 4'h9) | flags_q[`CBX_F_H]) ? 4'h6 : 4'h0};
   wire [7:0]  bcd_r  = flags_q[`CBX_F_N] ? (acc_q - bcd_c) : (acc_q + bcd_c);
   wire [15:0] w_neg  = 16'h0000 - primary_pair_q;
   wire        blk_down = bop_q[`CBX_BLK_DOWN];
   wire        blk_srch = bop_q[`CBX_BLK_SRCH];
   wire [15:0] cnt_nx   = counter_pair_q - 16'h0001;
   wire [15:0] hl_nx    = blk_down ? (primary_pair_q - 16'h0001) : (primary_pair_q + 16'h0001);
   wire [15:0] de_nx    = blk_down ? (secondary_pair_q - 16'h0001) : (secondary_pair_q + 16'h0001);
   wire        buf_push = (st_q == ST_RD) & mem_ack & !blk_srch & !buf_full;
   wire        buf_pop  = (st_q == ST_WR) & mem_ack & !buf_empty;
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
      end else begin
         if (buf_push) begin
            buf_q[wp_q] <= mem_rdata;
            wp_q <= ~wp_q;
         end
         if (buf_pop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_q <= ST_IDLE;
         bop_q <= 3'h0;
         acc_q <= 8'h00;
         flags_q <= 8'h00;
         counter_pair_q <= 16'h0000;
         secondary_pair_q <= 16'h0000;
         primary_pair_q <= 16'h0000;
         alu_done <= 1'b0;
         div_fault <= 1'b0;
         alu_dst_xreg <= 1'b0;
         alu_dst_opnd <= 1'b0;
         alu_opnd_out <= 16'h0000;
         blk_done <= 1'b0;
         blk_irq_exit <= 1'b0;
         blk_matched <= 1'b0;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_addr <= 16'h0000;
         mem_wdata <= 8'h00;
      end else begin
         alu_done <= 1'b0;
         div_fault <= 1'b0;
         alu_dst_xreg <= 1'b0;
         alu_dst_opnd <= 1'b0;
         blk_done <= 1'b0;
         blk_irq_exit <= 1'b0;
         if (load_en && st_q == ST_IDLE) begin
            acc_q <= load_acc;
            flags_q <= load_flags;
            counter_pair_q <= load_counter;
            secondary_pair_q <= load_secondary;
            primary_pair_q <= load_primary;
         end else if (alu_req && st_q == ST_IDLE) begin
            alu_done <= 1'b1;
            // (RQ7) Accumulator with operand
            case (alu_op)
               `CBX_OP_ADD, `CBX_OP_ADC: begin
                  acc_q <= b_add[7:0];
                  flags_q <= flg8(b_add[7:0], b_add[8], 1'b0,
                     (acc_q[7] == bop[7]) && (b_add[7] != acc_q[7]), b_add[4] ^ acc_q[4] ^ bop[4]);
               end
               `CBX_OP_SUB, `CBX_OP_SBC, `CBX_OP_CMP: begin
                  if (alu_op != `CBX_OP_CMP)
                     acc_q <= b_sub[7:0];
                  flags_q <= flg8(b_sub[7:0], b_sub[8], 1'b1,
                     (acc_q[7] != bop[7]) && (b_sub[7] != acc_q[7]), b_sub[4] ^ acc_q[4] ^ bop[4]);
               end
               `CBX_OP_AND: begin
                  acc_q <= acc_q & bop;
                  flags_q <= flg8(acc_q & bop, 1'b0, 1'b0, ~^(acc_q & bop), 1'b1);
               end
               `CBX_OP_OR: begin
                  acc_q <= acc_q | bop;
                  flags_q <= flg8(acc_q | bop, 1'b0, 1'b0, ~^(acc_q | bop), 1'b0);
               end
               `CBX_OP_XOR: begin
                  acc_q <= acc_q ^ bop;
                  flags_q <= flg8(acc_q ^ bop, 1'b0, 1'b0, ~^(acc_q ^ bop), 1'b0);
               end
               // (RQ8) Byte products to primary_pair
               `CBX_OP_MULU: begin
                  primary_pair_q <= b_mulu;
                  flags_q <= flg8(b_mulu[15:8], b_mulu[15:8] != 8'h00, 1'b0, 1'b0, 1'b0);
               end
               `CBX_OP_MULS: begin
                  primary_pair_q <= b_muls;
                  flags_q <= flg8(b_muls[15:8], b_muls[15:8] != {8{b_muls[7]}}, 1'b0, 1'b0, 1'b0);
               end
               // (RQ9) (RQ14) (RQ23) (RQ24) Byte divide
               `CBX_OP_DIVS, `CBX_OP_QUOTIENT_UNSIGNED: begin
                  if (b_den == 8'h00 || b_ovf) begin
                     div_fault <= 1'b1;
                     flags_q <= flg8(8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
                  end else begin
                     acc_q <= b_sgn ? b_qs : b_q[7:0];
                     primary_pair_q[7:0] <= b_sgn ? b_rs : b_r[7:0];
                     flags_q <= flg8(b_sgn ? b_qs : b_q[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
                  end
               end
               // (RQ10) Inc/dec written back
               `CBX_OP_INC: begin
                  alu_dst_opnd <= 1'b1;
                  alu_opnd_out <= {8'h00, bop + 8'h01};
                  flags_q <= flg8(bop + 8'h01, cin, 1'b0, bop == 8'h7F, bop[3:0] == 4'hF);
               end
               `CBX_OP_DEC: begin
                  alu_dst_opnd <= 1'b1;
                  alu_opnd_out <= {8'h00, bop - 8'h01};
                  flags_q <= flg8(bop - 8'h01, cin, 1'b1, bop == 8'h80, bop[3:0] == 4'h0);
               end
               // (RQ11) Accumulator only ops
               `CBX_OP_BCD: begin
                  acc_q <= bcd_r;
                  flags_q <= flg8(bcd_r, cin | (acc_q > 8'h99), flags_q[`CBX_F_N], ~^bcd_r, 1'b0);
               end
               `CBX_OP_ONES: begin
                  acc_q <= ~acc_q;
                  flags_q <= flags_q | 8'h12;
               end
               `CBX_OP_NEG: begin
                  acc_q <= 8'h00 - acc_q;
                  flags_q <= flg8(8'h00 - acc_q, acc_q != 8'h00, 1'b1, acc_q == 8'h80, acc_q[3:0] != 4'h0);
               end
               // (RQ12) (RQ13) Sign widen, flags kept
               `CBX_OP_SEXT: primary_pair_q <= {{8{acc_q[7]}}, acc_q};
               // (RQ18) (RQ22) Word ops on primary_pair
               `CBX_OP_WADD: begin
                  primary_pair_q <= w_add[15:0];
                  flags_q <= flg8(w_add[15:8], w_add[16], 1'b0,
                     (primary_pair_q[15] == alu_operand[15]) && (w_add[15] != primary_pair_q[15]), 1'b0)
                     & ~8'h40 | {1'b0, w_add[15:0] == 16'h0000, 6'h00};
               end
               `CBX_OP_WSUB, `CBX_OP_WCMP: begin
                  if (alu_op == `CBX_OP_WSUB)
                     primary_pair_q <= w_sub[15:0];
                  flags_q <= flg8(w_sub[15:8], w_sub[16], 1'b1,
                     (primary_pair_q[15] != alu_operand[15]) && (w_sub[15] != primary_pair_q[15]), 1'b0)
                     & ~8'h40 | {1'b0, w_sub[15:0] == 16'h0000, 6'h00};
               end
               // (RQ19) Word product split
               `CBX_OP_WMULU: begin
                  {secondary_pair_q, primary_pair_q} <= w_mulu;
                  flags_q <= flg8(w_mulu[31:24], w_mulu[31:16] != 16'h0000, 1'b0, 1'b0, 1'b0);
               end
               `CBX_OP_WMULS: begin
                  {secondary_pair_q, primary_pair_q} <= w_muls;
                  flags_q <= flg8(w_muls[31:24], w_muls[31:16] != {16{w_muls[15]}}, 1'b0, 1'b0, 1'b0);
               end
               // (RQ20) (RQ23) Word divide
               `CBX_OP_WDIVS, `CBX_OP_WDIVU: begin
                  if (w_den == 16'h0000 || w_ovf) begin
                     div_fault <= 1'b1;
                     flags_q <= flg8(8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
                  end else begin
                     primary_pair_q <= (w_sgn & w_qneg) ? (16'h0000 - w_q[15:0]) : w_q[15:0];
                     secondary_pair_q <= (w_sgn & w_dvd[31]) ? (16'h0000 - w_r[15:0]) : w_r[15:0];
                     flags_q <= flg8(w_q[15:8], 1'b0, 1'b0, 1'b0, 1'b0);
                  end
               end
               // (RQ21) Word sign widen
               `CBX_OP_WSEXT: secondary_pair_q <= {16{primary_pair_q[15]}};
               `CBX_OP_WNEG: begin
                  primary_pair_q <= w_neg;
                  flags_q <= flg8(w_neg[15:8], primary_pair_q != 16'h0000, 1'b1, primary_pair_q == 16'h8000, 1'b0)
                     & ~8'h40 | {1'b0, w_neg == 16'h0000, 6'h00};
               end
               // (RQ16) Word inc/dec, flags kept
               `CBX_OP_WINC: begin
                  alu_dst_opnd <= 1'b1;
                  alu_opnd_out <= alu_operand + 16'h0001;
               end
               `CBX_OP_WDEC: begin
                  alu_dst_opnd <= 1'b1;
                  alu_opnd_out <= alu_operand - 16'h0001;
               end
               // (RQ15) Addressing register result
               `CBX_OP_XADD, `CBX_OP_XADC: begin
                  alu_dst_xreg <= 1'b1;
                  alu_opnd_out <= x_adc[15:0];
                  flags_q[`CBX_F_C] <= x_adc[16];
               end
               `CBX_OP_XSBC: begin
                  alu_dst_xreg <= 1'b1;
                  alu_opnd_out <= x_sbc[15:0];
                  flags_q <= flg8(x_sbc[15:8], x_sbc[16], 1'b1, 1'b0, 1'b0)
                     & ~8'h40 | {1'b0, x_sbc[15:0] == 16'h0000, 6'h00};
               end
               // (RQ17) Signed byte index
               `CBX_OP_XADDA: begin
                  alu_dst_xreg <= 1'b1;
                  alu_opnd_out <= alu_xreg + {{8{acc_q[7]}}, acc_q};
               end
               default: alu_done <= 1'b1;
            endcase
         end else begin
            case (st_q)
               ST_IDLE: begin
                  if (blk_req) begin
                     // (RQ5) (RQ1) Pointers and 16-bit count
                     bop_q <= blk_op;
                     blk_matched <= 1'b0;
                     st_q <= ST_RD;
                     mem_rd <= 1'b1;
                     mem_addr <= primary_pair_q;
                  end
               end
               ST_RD: begin
                  if (mem_ack && (blk_srch || !buf_full)) begin
                     mem_rd <= 1'b0;
                     st_q <= blk_srch ? ST_STEP : ST_BUF;
                     if (blk_srch) begin
                        blk_matched <= (mem_rdata == acc_q);
                        flags_q <= flg8(acc_q - mem_rdata, cin, 1'b1, cnt_nx != 16'h0000, 1'b0);
                     end
                  end
               end
               ST_BUF: begin
                  mem_wr <= 1'b1;
                  mem_addr <= secondary_pair_q;
                  mem_wdata <= buf_head;
                  st_q <= ST_WR;
               end
               ST_WR: begin
                  if (mem_ack) begin
                     mem_wr <= 1'b0;
                     st_q <= ST_STEP;
                     flags_q[`CBX_F_PV] <= (cnt_nx != 16'h0000);
                     flags_q[`CBX_F_N] <= 1'b0;
                     flags_q[`CBX_F_H] <= 1'b0;
                  end
               end
               default: begin
                  // (RQ2) (RQ4) One unit, pointers stepped
                  counter_pair_q <= cnt_nx;
                  primary_pair_q <= hl_nx;
                  if (!blk_srch)
                     secondary_pair_q <= de_nx;
                  // (RQ3) Repeat until zero or match
                  if (!bop_q[`CBX_BLK_RUN] || cnt_nx == 16'h0000 || (blk_srch && blk_matched)) begin
                     blk_done <= 1'b1;
                     st_q <= ST_IDLE;
                  end else if (irq_pending) begin
                     // (RQ6) Exit between iterations
                     blk_irq_exit <= 1'b1;
                     st_q <= ST_IDLE;
                  end else begin
                     mem_rd <= 1'b1;
                     mem_addr <= hl_nx;
                     st_q <= ST_RD;
                  end
               end
            endcase
         end
      end
   end
endmodule // cbx_exec
`default_nettype wire

// [sim/cbx_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cbx_mem_model (
   input  wire logic        core_clk,
   input  wire logic        slow,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output var  logic        mem_ack,
   output var  logic [7:0]  mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [1:0] wait_q;
   initial begin
      mem_ack = 1'h0;
      mem_rdata = 8'hA5;
      wait_q = 2'h0;
      for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5A;
   end
   // Ack after zero or two wait cycles; idle data toggles
   always @(posedge core_clk) begin
      if ((mem_rd || mem_wr) && !mem_ack) begin
         if (wait_q == (slow ? 2'h2 : 2'h0)) begin
            mem_ack <= 1'h1;
            wait_q <= 2'h0;
            if (mem_rd) mem_rdata <= mem[mem_addr];
            else mem[mem_addr] <= mem_wdata;
         end else wait_q <= wait_q + 2'h1;
      end else begin
         mem_ack <= 1'h0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule // cbx_mem_model
`default_nettype wire

// [sim/cbx_exec_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cbx_defines.vh"
module cbx_exec_chk (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic [5:0]  alu_op,
   input wire logic        alu_done,
   input wire logic        div_fault,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic        mem_ack,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  mem_wdata,
   input wire logic        blk_irq_exit,
   input wire logic [7:0]  acc_q,
   input wire logic [7:0]  flags_q,
   input wire logic [15:0] counter_pair_q,
   input wire logic [15:0] secondary_pair_q,
   input wire logic [15:0] primary_pair_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   a_rd_hold: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
      else $error("read request not held");
   a_wr_hold: assert property (mem_wr && !mem_ack |=> mem_wr && $stable(mem_addr) && $stable(mem_wdata))
      else $error("write request not held");
   a_fault_div_only: assert property (div_fault |-> $past(alu_op) inside
      {`CBX_OP_DIVS, `CBX_OP_QUOTIENT_UNSIGNED, `CBX_OP_WDIVS, `CBX_OP_WDIVU}) else $error("fault from non divide");
   a_fault_keeps: assert property (div_fault |-> $stable(acc_q) && $stable(primary_pair_q)
      && $stable(secondary_pair_q)) else $error("fault changed registers");
   a_sext_byte: assert property (alu_done && $past(alu_op) == `CBX_OP_SEXT |->
      primary_pair_q == {{8{acc_q[7]}}, acc_q} && $stable(flags_q)) else $error("byte widen wrong");
   a_sext_word: assert property (alu_done && $past(alu_op) == `CBX_OP_WSEXT |->
      secondary_pair_q == {16{primary_pair_q[15]}} && $stable(flags_q)) else $error("word widen wrong");
   a_winc_flags: assert property (alu_done && $past(alu_op) inside {`CBX_OP_WINC, `CBX_OP_WDEC}
      |-> $stable(flags_q)) else $error("word step changed flags");
   a_irq_resume: assert property (blk_irq_exit |-> counter_pair_q != 16'h0000)
      else $error("interrupt exit with no work left");
endmodule // cbx_exec_chk
bind cbx_exec cbx_exec_chk cbx_exec_chk_i (.*);
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cbx_defines.vh"
module tb_top;
   logic        core_clk = 1'h0, reset = 1'h1, alu_req = 1'h0, blk_req = 1'h0, irq_pending = 1'h0;
   logic        load_en = 1'h0, slow = 1'h0, fault_seen;
   logic [5:0]  alu_op = 6'h00;
   logic [2:0]  blk_op = 3'h0;
   logic [7:0]  load_acc = 8'h00, load_flags = 8'h41;
   logic [15:0] alu_operand = 16'h0000, alu_xreg = 16'h0000, load_counter = 16'h0000;
   logic [15:0] load_secondary = 16'h0000, load_primary = 16'h0000;
   wire         alu_done, div_fault, alu_dst_xreg, alu_dst_opnd, blk_done, blk_irq_exit, blk_matched;
   wire         mem_rd, mem_wr, mem_ack;
   wire  [15:0] alu_opnd_out, mem_addr, counter_pair_q, secondary_pair_q, primary_pair_q;
   wire  [7:0]  mem_wdata, mem_rdata, acc_q, flags_q;
   int          fail_count = 0, num_checks = 0, cyc = 0;
   always #2.5 core_clk = ~core_clk;
   cbx_exec cbx_exec_i (.*);
   cbx_mem_model cbx_mem_model_i (.*);
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic load(input logic [7:0] a, input logic [15:0] c, input logic [15:0] s, input logic [15:0] p);
      @(posedge core_clk) #1 load_en = 1'h1;
      load_acc = a;
      load_counter = c;
      load_secondary = s;
      load_primary = p;
      @(posedge core_clk) #1 load_en = 1'h0;
   endtask
   task automatic alu(input logic [5:0] op, input logic [15:0] opnd, input logic [15:0] xr);
      int n = 0;
      @(posedge core_clk) #1 alu_req = 1'h1;
      alu_op = op;
      alu_operand = opnd;
      alu_xreg = xr;
      @(posedge core_clk) #1 alu_req = 1'h0;
      while (alu_done !== 1'h1 && div_fault !== 1'h1 && n < 8)
         @(posedge core_clk) #1 n++;
      fault_seen = div_fault;
      chk("alu finish", n < 8, 1'h1);
   endtask
   task automatic blk(input logic [2:0] op);
      int n = 0;
      @(posedge core_clk) #1 blk_req = 1'h1;
      blk_op = op;
      @(posedge core_clk) #1 blk_req = 1'h0;
      while (blk_done !== 1'h1 && blk_irq_exit !== 1'h1 && n < 3000)
         @(posedge core_clk) #1 n++;
      chk("blk finish", n < 3000, 1'h1);
   endtask
   task automatic t_byte();
      for (int k = 0; k < 33; k++) alu(k[5:0], 16'h0003, 16'h0001);
      load(8'h3C, 16'h0000, 16'h0000, 16'h0000);
      alu(`CBX_OP_ADD, 16'h0055, 16'h0000);
      chk("add acc", acc_q, 8'h91);
      alu(`CBX_OP_MULU, 16'h0012, 16'h0000);
      chk("mul primary", primary_pair_q, 16'h0A32);
      alu(`CBX_OP_ONES, 16'h00FF, 16'h0000);
      chk("ones acc", acc_q, 8'h6E);
      load(8'h85, 16'h0000, 16'h0000, 16'h0000);
      alu(`CBX_OP_SEXT, 16'h0000, 16'h0000);
      chk("widen primary", primary_pair_q, 16'hFF85);
      chk("widen flags", flags_q, 8'h41);
      $display("t_byte done");
   endtask
   task automatic t_word();
      load(8'h00, 16'h0000, 16'h0000, 16'h1234);
      alu(`CBX_OP_WMULU, 16'h0100, 16'h0000);
      chk("wmul high", secondary_pair_q, 16'h0012);
      chk("wmul low", primary_pair_q, 16'h3400);
      load(8'h00, 16'h0000, 16'h0001, 16'h0005);
      alu(`CBX_OP_WDIVU, 16'h0010, 16'h0000);
      chk("wdiv quot", primary_pair_q, 16'h1000);
      chk("wdiv rem", secondary_pair_q, 16'h0005);
      load(8'h00, 16'h0000, 16'h0000, 16'h0107);
      alu(`CBX_OP_QUOTIENT_UNSIGNED, 16'h0010, 16'h0000);
      chk("div quot", acc_q, 8'h10);
      chk("div rem", primary_pair_q[7:0], 8'h07);
      alu(`CBX_OP_QUOTIENT_UNSIGNED, 16'h0000, 16'h0000);
      chk("div zero", fault_seen, 1'h1);
      load(8'hFE, 16'h0000, 16'h0000, 16'h8000);
      alu(`CBX_OP_XADDA, 16'h0000, 16'h1000);
      chk("index add", {alu_dst_xreg, alu_opnd_out}, 17'h10FFE);
      alu(`CBX_OP_WINC, 16'h00FF, 16'h0000);
      chk("word inc", {alu_dst_opnd, alu_opnd_out}, 17'h10100);
      alu(`CBX_OP_WSEXT, 16'h0000, 16'h0000);
      chk("word widen", secondary_pair_q, 16'hFFFF);
      $display("t_word done");
   endtask
   task automatic t_copy();
      load(8'h00, 16'h0003, 16'h0200, 16'h0100);
      blk(3'h2);
      for (int k = 0; k < 3; k++) chk("copy up", cbx_mem_model_i.mem[16'h0200 + k], pat(16'h0100 + k));
      chk("copy ptrs", {counter_pair_q, secondary_pair_q, primary_pair_q}, 48'h000002030103);
      slow = 1'h1;
      load(8'h00, 16'h0002, 16'h0210, 16'h0110);
      blk(3'h1);
      chk("step byte", cbx_mem_model_i.mem[16'h0210], pat(16'h0110));
      chk("step ptrs", {counter_pair_q, secondary_pair_q, primary_pair_q}, 48'h0001020F010F);
      $display("t_copy done");
   endtask
   task automatic t_search();
      load(pat(16'h0303), 16'h0008, 16'h0000, 16'h0300);
      blk(3'h6);
      chk("search hit", {blk_matched, counter_pair_q, primary_pair_q}, 33'h100040304);
      blk(3'h5);
      chk("search step", {blk_matched, counter_pair_q, primary_pair_q}, 33'h000030303);
      $display("t_search done");
   endtask
   task automatic t_irq();
      load(8'h00, 16'h0006, 16'h0400, 16'h0500);
      irq_pending = 1'h1;
      blk(3'h2);
      irq_pending = 1'h0;
      chk("irq exit", {blk_irq_exit, counter_pair_q, primary_pair_q}, 33'h100050501);
      blk(3'h2);
      for (int k = 0; k < 6; k++) chk("resume copy", cbx_mem_model_i.mem[16'h0400 + k], pat(16'h0500 + k));
      chk("resume count", counter_pair_q, 16'h0000);
      $display("t_irq done");
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      #1 reset = 1'h0;
      t_byte();
      t_word();
      t_copy();
      t_search();
      t_irq();
      close_out();
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end
endmodule // tb_top
`default_nettype wire
